// ### core/reset_source_supervisor.sv
// Reset source collector, supply monitor control, watchdog and APB registers
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "reset_supervisor_cfg.svh"

module reset_source_supervisor #(
	parameter int ADDR_W   = 8,
	parameter int WDT_W    = 32,
	parameter int BUZZ_W   = 16,
	parameter int BUZZ_LEN = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              powerOnTrip,
	input  wire logic              presDigitalTrip,
	input  wire logic              presAnalogTrip,
	input  wire logic              analogLowTrip,
	input  wire logic              digitalLowTrip,
	input  wire logic              analogHighTrip,
	input  wire logic              externalResetPin_n,
	input  wire logic              sleepMode,
	input  wire logic              hibernateMode,
	input  wire logic              bootDone,
	output logic                   systemReset_n,
	output logic                   powerOnMonitorEn,
	output logic                   presDigitalEn,
	output logic                   presAnalogEn,
	output logic                   rangeMonitorEn,
	output logic                   analogRegulatorEn,
	output logic [3:0]             analogLowLevel,
	output logic [3:0]             digitalLowLevel,
	output logic                   buzzActive,
	output logic                   wakeupRequest,
	output logic                   monitorIrq
);

	localparam int ResetMinCycles = (`RSS_RST_MIN_NS + `RSS_CLK_PERIOD_NS - 1)
		/ `RSS_CLK_PERIOD_NS;

	generate
		if (WDT_W < 2 || WDT_W > 32 || BUZZ_W < 2 || BUZZ_W > 32 || BUZZ_LEN < 1
			|| (BUZZ_W < 31 && BUZZ_LEN >= (1 << BUZZ_W)) || ADDR_W < 5 || ADDR_W > 32
			|| ResetMinCycles > 31) begin : g_badParam
			$error("reset_source_supervisor: unsupported parameter value");
		end
	endgenerate

	function automatic logic apbWrite(input logic [ADDR_W-1:0] addr,
		input logic [7:0] offset);
		apbWrite = psel && penable && pwrite && (addr == ADDR_W'(offset));
	endfunction : apbWrite

	reset_supervisor_pkg::sup_state_e state_q;
	reset_supervisor_pkg::sup_state_e state_d;
	reset_supervisor_pkg::status_s    status_q;
	reset_supervisor_pkg::status_s    statusSet;
	reset_supervisor_pkg::status_s    statusClr;
	reset_supervisor_pkg::ctrl_s      ctrl_q;
	reset_supervisor_pkg::level_s     level_q;

	logic [BUZZ_W-1:0] buzzInterval_q;
	logic [BUZZ_W-1:0] buzzCnt_q;
	logic              buzzWin_q;
	logic [WDT_W-1:0]  wdtPeriod_q;
	logic [WDT_W-1:0]  wdtCnt_q;
	logic              wdtEnable_q;
	logic              xresMeta_q;
	logic              xresSync_q;
	logic [4:0]        holdCnt_q;
	logic              porMonitorEn_q;
	logic              porActive;
	logic              powerOnClear;
	logic              awake;
	logic              monitorWindow;
	logic              presTrip;
	logic              alvTrip;
	logic              dlvTrip;
	logic              ahvTrip;
	logic              lvResetTrip;
	logic              swResetFire;
	logic              wdtKick;
	logic              wdtFire;
	logic              anySource;
	logic              inHold;

	// Power-on monitor only counts until boot hands over
	assign porActive    = porMonitorEn_q && powerOnTrip; // R2
	assign powerOnClear = !rst_n || porActive;
	assign inHold       = (state_q == reset_supervisor_pkg::ST_HOLD);
	assign awake        = !sleepMode && !hibernateMode;
	assign monitorWindow = (state_q == reset_supervisor_pkg::ST_RUN)
		&& (awake || (sleepMode && !hibernateMode && buzzWin_q)); // R5 R9

	// Pin synchroniser; only the second stage is used
	// Starts at the pull-up level so a block reset records no false pin reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			xresMeta_q <= 1'b1;
			xresSync_q <= 1'b1;
		end else begin
			xresMeta_q <= externalResetPin_n; // R22 R13
			xresSync_q <= xresMeta_q;
		end
	end

	assign presTrip = (presDigitalEn && presDigitalTrip)
		|| (presAnalogEn && presAnalogTrip); // R3
	assign alvTrip  = rangeMonitorEn && ctrl_q.alvEnable && analogLowTrip;
	assign dlvTrip  = rangeMonitorEn && ctrl_q.dlvEnable && digitalLowTrip;
	assign ahvTrip  = rangeMonitorEn && ctrl_q.ahvEnable && analogHighTrip; // R7
	assign lvResetTrip = (alvTrip && ctrl_q.alvResetMode)
		|| (dlvTrip && ctrl_q.dlvResetMode); // R8

	assign swResetFire = apbWrite(paddr, `RSS_OFF_CTRL) && pwdata[`RSS_CTRL_SW_RESET]
		&& !ctrl_q.swResetBlock; // R15 R16
	assign wdtKick = apbWrite(paddr, `RSS_OFF_WDT_CTRL) && pwdata[`RSS_WDT_KICK];

	assign anySource = porActive || presTrip || !xresSync_q || swResetFire
		|| wdtFire || lvResetTrip; // R22 R12

	// Hold counter stretches every source to the least reset width
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			holdCnt_q <= 5'(ResetMinCycles);
		end else if (anySource) begin
			holdCnt_q <= 5'(ResetMinCycles); // R1
		end else if (holdCnt_q != 5'h00) begin
			holdCnt_q <= holdCnt_q - 5'h01;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			reset_supervisor_pkg::ST_HOLD: begin
				if (!anySource && holdCnt_q == 5'h00) begin
					state_d = reset_supervisor_pkg::ST_BOOT;
				end
			end
			reset_supervisor_pkg::ST_BOOT: begin
				if (anySource) begin
					state_d = reset_supervisor_pkg::ST_HOLD;
				end else if (bootDone) begin
					state_d = reset_supervisor_pkg::ST_RUN;
				end
			end
			reset_supervisor_pkg::ST_RUN: begin
				if (anySource) begin
					state_d = reset_supervisor_pkg::ST_HOLD;
				end
			end
			default: state_d = reset_supervisor_pkg::ST_HOLD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= reset_supervisor_pkg::ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	// One reset line for processor, peripherals and their registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			systemReset_n <= 1'b0;
		end else begin
			systemReset_n <= (state_d != reset_supervisor_pkg::ST_HOLD); // R21 R22
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			porMonitorEn_q <= 1'b1;
		end else if (state_q == reset_supervisor_pkg::ST_BOOT && bootDone) begin
			porMonitorEn_q <= 1'b0; // R2
		end
	end
	assign powerOnMonitorEn = porMonitorEn_q;

	// Monitor enables; digital precise part has no software control
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			presDigitalEn  <= 1'b0;
			presAnalogEn   <= 1'b0;
			rangeMonitorEn <= 1'b0;
		end else begin
			presDigitalEn  <= monitorWindow && !porMonitorEn_q; // R4 R5
			presAnalogEn   <= monitorWindow && !porMonitorEn_q && ctrl_q.analogRegEnable; // R4
			rangeMonitorEn <= monitorWindow && !porMonitorEn_q; // R9
		end
	end

	// Sleep buzz timer: interval, then a short sampling window
	always_ff @(posedge clk) begin
		if (!rst_n || inHold || !sleepMode || hibernateMode) begin
			buzzCnt_q <= '0;
			buzzWin_q <= 1'b0;
		end else if (buzzWin_q) begin
			if (buzzCnt_q >= BUZZ_W'(BUZZ_LEN - 1)) begin
				buzzCnt_q <= '0;
				buzzWin_q <= 1'b0;
			end else begin
				buzzCnt_q <= buzzCnt_q + 1'b1;
			end
		end else if (buzzCnt_q >= buzzInterval_q) begin
			buzzCnt_q <= '0;
			buzzWin_q <= 1'b1; // R5 R9
		end else begin
			buzzCnt_q <= buzzCnt_q + 1'b1;
		end
	end
	assign buzzActive = buzzWin_q;

	// Watchdog: counts while enabled, restarted by a kick write
	always_ff @(posedge clk) begin
		if (powerOnClear) begin
			wdtEnable_q <= 1'b0; // R18
		end else if (apbWrite(paddr, `RSS_OFF_WDT_CTRL) && pwdata[`RSS_WDT_ENABLE]) begin
			wdtEnable_q <= 1'b1; // R19
		end
	end

	assign wdtFire = wdtEnable_q && !inHold && (wdtCnt_q >= wdtPeriod_q); // R17

	always_ff @(posedge clk) begin
		if (!rst_n || inHold || !wdtEnable_q || wdtKick || wdtFire) begin
			wdtCnt_q <= '0;
		end else begin
			wdtCnt_q <= wdtCnt_q + 1'b1;
		end
	end

	// Control registers return to defaults on every system reset
	always_ff @(posedge clk) begin
		if (!rst_n || inHold) begin
			ctrl_q         <= reset_supervisor_pkg::ctrl_s'(`RSS_CTRL_RST); // R21
			level_q        <= reset_supervisor_pkg::level_s'(`RSS_LEVEL_RST);
			buzzInterval_q <= BUZZ_W'(`RSS_BUZZ_RST);
			wdtPeriod_q    <= WDT_W'(`RSS_WDT_PERIOD_RST);
		end else begin
			if (apbWrite(paddr, `RSS_OFF_CTRL)) begin
				ctrl_q            <= reset_supervisor_pkg::ctrl_s'(pwdata[7:0]);
				ctrl_q.swResetReq <= 1'b0;
			end
			if (apbWrite(paddr, `RSS_OFF_LEVEL)) begin
				level_q <= reset_supervisor_pkg::level_s'(pwdata[7:0]); // R6
			end
			if (apbWrite(paddr, `RSS_OFF_BUZZ)) begin
				buzzInterval_q <= pwdata[BUZZ_W-1:0];
			end
			if (apbWrite(paddr, `RSS_OFF_WDT_PERIOD)) begin
				wdtPeriod_q <= pwdata[WDT_W-1:0];
			end
		end
	end

	assign analogRegulatorEn = ctrl_q.analogRegEnable; // R4
	assign analogLowLevel    = level_q.analogLowLevel; // R6
	assign digitalLowLevel   = level_q.digitalLowLevel; // R6

	// Status record: sticky, write one to clear, a new event beats the clear
	always_comb begin
		statusSet           = '0;
		statusSet.porReset  = porActive;
		statusSet.presReset = presTrip;
		statusSet.extReset  = !xresSync_q;
		statusSet.swReset   = swResetFire;
		statusSet.wdtReset  = wdtFire;
		statusSet.lvReset   = lvResetTrip;
		statusSet.alvIrq    = alvTrip && !ctrl_q.alvResetMode;
		statusSet.dlvIrq    = dlvTrip && !ctrl_q.dlvResetMode;
		statusSet.ahvIrq    = ahvTrip;
		statusClr           = '0;
		if (apbWrite(paddr, `RSS_OFF_STATUS)) begin
			statusClr = reset_supervisor_pkg::status_s'(pwdata[8:0]);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status_q <= '0; // R20
		end else if (porActive) begin
			status_q           <= '0; // R20
			status_q.porReset  <= 1'b1;
		end else begin
			status_q <= (status_q & ~statusClr) | statusSet; // R20
		end
	end

	// Interrupts raised in a buzz wake the device first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wakeupRequest <= 1'b0;
			monitorIrq    <= 1'b0;
		end else begin
			wakeupRequest <= (status_q.alvIrq || status_q.dlvIrq || status_q.ahvIrq)
				&& !awake; // R10
			monitorIrq    <= (status_q.alvIrq || status_q.dlvIrq || status_q.ahvIrq)
				&& awake && !inHold; // R10 R7
		end
	end

	// APB slave: zero wait states, error on unmapped offsets
	assign pready = 1'b1;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			case (paddr)
				ADDR_W'(`RSS_OFF_CTRL):       prdata[7:0] <= 8'(ctrl_q);
				ADDR_W'(`RSS_OFF_LEVEL):      prdata[7:0] <= 8'(level_q);
				ADDR_W'(`RSS_OFF_BUZZ):       prdata[BUZZ_W-1:0] <= buzzInterval_q;
				ADDR_W'(`RSS_OFF_WDT_CTRL):   prdata[`RSS_WDT_ENABLE] <= wdtEnable_q;
				ADDR_W'(`RSS_OFF_WDT_PERIOD): prdata[WDT_W-1:0] <= wdtPeriod_q;
				ADDR_W'(`RSS_OFF_STATUS):     prdata[8:0] <= 9'(status_q);
				ADDR_W'(`RSS_OFF_STATE): begin
					prdata[1:0] <= 2'(state_q);
					prdata[2]   <= porMonitorEn_q;
					prdata[3]   <= presDigitalEn;
					prdata[4]   <= presAnalogEn;
					prdata[5]   <= rangeMonitorEn;
					prdata[6]   <= buzzWin_q;
					prdata[7]   <= xresSync_q;
				end
				default:                      pslverr <= 1'b1;
			endcase
		end
	end

endmodule : reset_source_supervisor

// ### core/reset_supervisor_cfg.svh
// Offsets, field positions, reset values and times in ns and us of the reset supervisor
// How it works
// R1 - Power-on pulse lasts at least 150 ns, longer while a supply ramps
// R2 - After boot the power-on monitor is off, precise monitor takes over
// R3 - Precise monitor trip gives the same reset as power-on
// R4 - Software cannot stop digital precise monitor; analog part follows analog regulator
// R5 - Precise monitor off in sleep and hibernate, on only during buzz
// R6 - Low-voltage trip levels 1.70 V to 5.45 V in 250 mV steps
// R7 - High-voltage monitor trips at fixed 5.75 V and raises an interrupt
// R8 - Each low-voltage monitor may reset the device instead of interrupting
// R9 - Range monitors off until power-on done; in sleep only at buzz
// R10 - Buzz interrupt first wakes the device, then is presented
// R11 - Software sets buzz interval shorter than any supply excursion
// R12 - Low reset pin holds reset like power-on; pin has pull-up
// R13 - Reset pin works in sleep and hibernate
// R14 - External driver waits 10 us before asserting the pin again
// R15 - Software reset bit, written by processor or DMA, resets like power-on
// R16 - A separate bit blocks the software reset bit
// R17 - Watchdog not restarted within its period resets the device
// R18 - Power-on leaves watchdog disabled; firmware enables it by a bit
// R19 - Watchdog enable stays set; only power-on clears it
// R20 - Status register records resets and monitor interrupts; power-on clears it
// R21 - System reset covers processor, peripherals and their registers
// R22 - All sources ORed into one reset; pin synchronised before use
`ifndef RESET_SUPERVISOR_CFG_SVH
`define RESET_SUPERVISOR_CFG_SVH

`define RSS_CLK_PERIOD_NS   10
`define RSS_RST_MIN_NS      150
`define RSS_EXTERNAL_RESET_PIN_N_GAP_US     10

`define RSS_OFF_CTRL        8'h00
`define RSS_OFF_LEVEL       8'h04
`define RSS_OFF_BUZZ        8'h08
`define RSS_OFF_WDT_CTRL    8'h0C
`define RSS_OFF_WDT_PERIOD  8'h10
`define RSS_OFF_STATUS      8'h14
`define RSS_OFF_STATE       8'h18

`define RSS_CTRL_SW_RESET   0
`define RSS_CTRL_SW_BLOCK   1
`define RSS_CTRL_ANA_REG    2
`define RSS_CTRL_ALV_EN     3
`define RSS_CTRL_DLV_EN     4
`define RSS_CTRL_AHV_EN     5
`define RSS_CTRL_ALV_RST    6
`define RSS_CTRL_DLV_RST    7
`define RSS_WDT_ENABLE      0
`define RSS_WDT_KICK        1

`define RSS_CTRL_RST        8'h04
`define RSS_LEVEL_RST       8'h00
`define RSS_BUZZ_RST        16'h03E8
`define RSS_WDT_PERIOD_RST  32'h000F_4240

`endif

// ### core/reset_supervisor_pkg.sv
// Types shared by the reset supervisor
package reset_supervisor_pkg;

	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_BOOT = 2'b01,
		ST_RUN  = 2'b11
	} sup_state_e;

	typedef struct packed {
		logic ahvIrq;
		logic dlvIrq;
		logic alvIrq;
		logic lvReset;
		logic wdtReset;
		logic swReset;
		logic extReset;
		logic presReset;
		logic porReset;
	} status_s;

	typedef struct packed {
		logic dlvResetMode;
		logic alvResetMode;
		logic ahvEnable;
		logic dlvEnable;
		logic alvEnable;
		logic analogRegEnable;
		logic swResetBlock;
		logic swResetReq;
	} ctrl_s;

	typedef struct packed {
		logic [3:0] digitalLowLevel;
		logic [3:0] analogLowLevel;
	} level_s;

endpackage : reset_supervisor_pkg

// ### verif/reset_supervisor_properties.sv
// Checker on the ports of the reset source supervisor
`timescale 1ns/1ps
module reset_supervisor_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic powerOnTrip,
	input wire logic externalResetPin_n,
	input wire logic sleepMode,
	input wire logic hibernateMode,
	input wire logic systemReset_n,
	input wire logic powerOnMonitorEn,
	input wire logic presDigitalEn,
	input wire logic presAnalogEn,
	input wire logic rangeMonitorEn,
	input wire logic analogRegulatorEn,
	input wire logic buzzActive,
	input wire logic wakeupRequest,
	input wire logic monitorIrq
);
	logic [15:0] lowCnt_q;

	// Length of the current system reset pulse in cycles
	always_ff @(posedge clk) begin
		if (!rst_n || systemReset_n)
			lowCnt_q <= 16'h0000;
		else if (lowCnt_q != 16'hFFFF)
			lowCnt_q <= lowCnt_q + 16'h0001;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	pin_hold_a: assert property (!externalResetPin_n [*4] |-> !systemReset_n)
		else $error("reset pin low but system reset released");
	por_trip_a: assert property (powerOnMonitorEn && powerOnTrip |-> ##[1:2] !systemReset_n)
		else $error("power-on trip gave no reset");
	min_pulse_a: assert property ($rose(systemReset_n) |-> lowCnt_q >= 16'h000F)
		else $error("system reset pulse too short");
	mon_off_por_a: assert property (powerOnMonitorEn |-> !rangeMonitorEn && !presDigitalEn)
		else $error("monitor enabled before power-on done");
	precise_regulator_monitor_awake_a: assert property ((systemReset_n && !powerOnMonitorEn && !sleepMode
		&& !hibernateMode) [*4] |-> presDigitalEn)
		else $error("precise monitor off while awake");
	sleep_off_a: assert property (((sleepMode && !buzzActive) || hibernateMode) [*2]
		|-> !presDigitalEn && !rangeMonitorEn)
		else $error("monitor on outside buzz window");
	ana_follow_a: assert property (!analogRegulatorEn [*2] |-> !presAnalogEn)
		else $error("analog precise monitor on with regulator off");
	irq_after_wake_a: assert property ($rose(monitorIrq)
		|-> !$past(sleepMode) && !$past(hibernateMode))
		else $error("interrupt presented before wakeup");

	cover property ($rose(wakeupRequest));
	cover property ($fell(systemReset_n) && !powerOnMonitorEn);
	cover property (buzzActive && presDigitalEn);
endmodule : reset_supervisor_properties

bind reset_source_supervisor reset_supervisor_properties chk (
	.clk, .rst_n, .powerOnTrip, .externalResetPin_n, .sleepMode, .hibernateMode,
	.systemReset_n, .powerOnMonitorEn, .presDigitalEn, .presAnalogEn, .rangeMonitorEn,
	.analogRegulatorEn, .buzzActive, .wakeupRequest, .monitorIrq
);

// ### verif/supply_partner.sv
// Model of the reset pin driver and the supply comparators
`timescale 1ns/1ps
module supply_partner #(
	parameter int RAMP = 30,
	parameter int GAP  = 1000
) (
	input  wire logic       clk,
	input  wire logic       pullLow,
	input  wire logic [5:0] tripReq,
	output logic      [5:0] trip,
	output logic            pin_n
);
	int   rampCnt = 0;
	int   gapCnt  = GAP;
	logic drive   = 1'b0;

	always @(posedge clk) begin
		if (rampCnt < RAMP)
			rampCnt <= rampCnt + 1;
	end

	// Pin pulled low only once the gap since the last release has run out
	always @(posedge clk) begin
		if (drive && !pullLow) begin
			drive <= 1'b0;
			gapCnt <= 0;
		end else if (!drive && pullLow && gapCnt >= GAP) begin
			drive <= 1'b1;
		end else if (gapCnt < GAP) begin
			gapCnt <= gapCnt + 1;
		end
	end

	// Supply still ramping keeps the power-on comparator tripped
	assign trip = {tripReq[5:1], tripReq[0] || rampCnt < RAMP};
	assign pin_n = drive ? 1'b0 : 1'b1;
endmodule : supply_partner

// ### verif/testbench.sv
// Self-checking bench for the reset source supervisor
`timescale 1ns/1ps
module testbench;
	logic        clk;
	logic        rst_n;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [5:0]  tripReq;
	logic [5:0]  trip;
	logic        pullLow;
	logic        pin_n;
	logic        sleepMode;
	logic        hibernateMode;
	logic        bootDone;
	logic        systemReset_n;
	logic        monitorIrq;
	logic        wakeupRequest;
	logic [3:0]  analogLowLevel;
	logic [3:0]  digitalLowLevel;
	int          n_mismatch = 0;
	int          compares   = 0;
	int          cycles     = 0;
	int          seed       = 32'h2F78655C;
	logic [7:0]  ctrlTab [7] = '{8'h04, 8'h04, 8'h0C, 8'h14, 8'h24, 8'h4C, 8'h94};
	int          idxTab  [7] = '{1, 2, 3, 4, 5, 3, 4};
	logic [7:0]  rstAddr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
	logic [31:0] rstVal  [7] = '{32'h4, 32'h0, 32'h3E8, 32'h0, 32'hF4240, 32'h1, 32'h0};

	reset_source_supervisor uut (
		.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
		.powerOnTrip(trip[0]), .presDigitalTrip(trip[1]), .presAnalogTrip(trip[2]),
		.analogLowTrip(trip[3]), .digitalLowTrip(trip[4]), .analogHighTrip(trip[5]),
		.externalResetPin_n(pin_n), .sleepMode, .hibernateMode, .bootDone, .systemReset_n,
		.powerOnMonitorEn(), .presDigitalEn(), .presAnalogEn(), .rangeMonitorEn(),
		.analogRegulatorEn(), .analogLowLevel, .digitalLowLevel, .buzzActive(),
		.wakeupRequest, .monitorIrq
	);

	supply_partner #(.RAMP(30), .GAP(1000)) partner (
		.clk, .pullLow, .tripReq, .trip, .pin_n
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude();
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check("prdata", r, exp);
		check("pslverr", {31'b0, e}, {31'b0, a > 8'h18});
	endtask : rd

	task automatic waitRst(input logic v);
		int n;
		n = 0;
		while (systemReset_n !== v && n < 300) begin
			@(posedge clk);
			n++;
		end
		check("systemReset_n", {31'b0, systemReset_n}, {31'b0, v});
	endtask : waitRst

	function automatic logic [31:0] statusBit(input int idx, input logic rm);
		if (idx < 3)
			return 32'h00000002;
		if (idx == 5)
			return 32'h00000100;
		return rm ? 32'h00000020 : 32'h00000001 << (idx + 3);
	endfunction : statusBit

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		logic [7:0]  v;
		logic [31:0] r;
		logic        e;
		logic        irq;
		int          n;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		tripReq = 6'h00;
		pullLow = 1'b0;
		sleepMode = 1'b0;
		hibernateMode = 1'b0;
		bootDone = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		waitRst(1'b1);
		bootDone <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, 8'h18, 32'h0, r, e);
		check("state", r & 32'h1F, 32'h1B);
		foreach (rstAddr[i]) rd(rstAddr[i], rstVal[i]);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
			wr(8'h04, {24'h0, v});
			rd(8'h04, {24'h0, v});
			check("level", {24'h0, digitalLowLevel, analogLowLevel}, {24'h0, v});
		end
		wr(8'h14, 32'h1FF);
		wr(8'h00, 32'h06);
		wr(8'h00, 32'h07);
		repeat (4) @(posedge clk);
		check("blocked", {31'b0, systemReset_n}, 32'h1);
		rd(8'h14, 32'h00);
		wr(8'h00, 32'h04);
		wr(8'h00, 32'h05);
		waitRst(1'b0);
		waitRst(1'b1);
		rd(8'h14, 32'h08);
		wr(8'h14, 32'h1FF);
		sleepMode <= 1'b1;
		pullLow <= 1'b1;
		waitRst(1'b0);
		repeat (20) @(posedge clk);
		pullLow <= 1'b0;
		sleepMode <= 1'b0;
		waitRst(1'b1);
		rd(8'h14, 32'h04);
		foreach (ctrlTab[i]) begin
			irq = idxTab[i] > 2 && !(ctrlTab[i][6] || ctrlTab[i][7]);
			wr(8'h14, 32'h1FF);
			wr(8'h00, {24'h0, ctrlTab[i]});
			tripReq <= 6'h01 << idxTab[i];
			repeat (6) @(posedge clk);
			check("monitorIrq", {31'b0, monitorIrq}, {31'b0, irq});
			check("tripReset", {31'b0, systemReset_n}, {31'b0, irq});
			tripReq <= 6'h00;
			waitRst(1'b1);
			rd(8'h14, statusBit(idxTab[i], ctrlTab[i][6] | ctrlTab[i][7]));
		end
		wr(8'h00, 32'h00);
		@(posedge clk);
		tripReq <= 6'h04;
		repeat (6) @(posedge clk);
		check("anaOff", {31'b0, systemReset_n}, 32'h1);
		tripReq <= 6'h02;
		repeat (6) @(posedge clk);
		check("digOn", {31'b0, systemReset_n}, 32'h0);
		tripReq <= 6'h00;
		waitRst(1'b1);
		wr(8'h14, 32'h1FF);
		wr(8'h08, 32'd20);
		wr(8'h00, 32'h0C);
		sleepMode <= 1'b1;
		repeat (3) @(posedge clk);
		tripReq <= 6'h08;
		n = 0;
		while (wakeupRequest !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check("wakeupRequest", {31'b0, wakeupRequest}, 32'h1);
		check("sleepIrq", {31'b0, monitorIrq}, 32'h0);
		tripReq <= 6'h00;
		hibernateMode <= 1'b1;
		repeat (5) @(posedge clk);
		hibernateMode <= 1'b0;
		sleepMode <= 1'b0;
		repeat (4) @(posedge clk);
		check("wakeIrq", {31'b0, monitorIrq}, 32'h1);
		wr(8'h14, 32'h1FF);
		wr(8'h10, 32'd20);
		wr(8'h0C, 32'h1);
		wr(8'h0C, 32'h0);
		repeat (6) begin
			repeat (($random(seed) & 7) + 1) @(posedge clk);
			wr(8'h0C, 32'h2);
		end
		apb(1'b0, 8'h0C, 32'h0, r, e);
		check("wdtEnable", {31'b0, r[0]}, 32'h1);
		check("kicked", {31'b0, systemReset_n}, 32'h1);
		waitRst(1'b0);
		waitRst(1'b1);
		rd(8'h14, 32'h10);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		waitRst(1'b1);
		rd(8'h0C, 32'h00);
		rd(8'h14, 32'h00);
		conclude();
	end
endmodule : testbench
